// ---- verilog/uhim_dev.sv ----
// Register bank end: interrupt mask with set and clear views, frame
// length and packet budget, frame timer and packet budget counter.
// Assumes commands, events and bit ticks come from the clk_i domain.
//
// Behaviour
// - Write one clears mask bit, zero keeps
// - Clear view reads back the live mask
// - Clear view codes 05 read, 85 write
// - Bit 31 one clears global gate
// - Event bits 6,5,4,3,2,0; rest reserved
// - Frame length codes 0D read, 8D write
// - Bits 13:0 frame length, default 11999
// - Controller soft reset restores default length
// - Software saves length before soft reset
// - Software may tune length each frame
// - Software inverts toggle on each write; host end only inverts it on restore and tune
// - Frame start loads packet budget counter
// - Budget counter bounds the bits of all transactions in one frame
// - Software computes the packet budget value
// - Interrupt needs event, mask and gate
// - Mask set view codes 04/84, one sets
// - Timer at zero reloads on bit tick
// - Timer at zero copies the toggle bit
`timescale 1ns/100ps
`include "uhim_defs.svh"

module uhim_dev
   import uhim_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   uhim_if.dev_mp bus,
   input wire logic soft_reset_i,
   input wire logic bit_tick_i,
   input wire logic [6:0] event_flags_i,
   input wire logic xfer_valid_i,
   input wire logic [14:0] xfer_bits_i,
   output logic xfer_fits_o,
   output logic sched_overrun_o,
   output logic irq_o,
   output logic [13:0] frame_left_o,
   output logic remaining_toggle_o,
   output logic [14:0] packet_left_o,
   output logic [31:0] irq_mask_o
);

   localparam uhim_dev_s RST = '{
      mask: `UHIM_MASK_RST,
      fi: `UHIM_FI_RST,
      budget: `UHIM_BUDGET_RST,
      default: '0
   };

   localparam logic [31:0] VALID = `UHIM_MASK_VALID;

   uhim_dev_s q;
   uhim_dev_s d;
   logic [31:0] wmask;
   logic fits;

   // Writes only ever touch defined bits, so stored reserved bits stay 0
   assign wmask = bus.cmd_wdata & VALID;

   // Budget check against what is left of this frame
   assign fits = (xfer_bits_i <= q.pkt);

   always_comb begin
      d = q;
      d.rsp_valid = 1'b0;
      d.sof = 1'b0;
      d.ovr = 1'b0;

      if (bus.cmd_valid) begin
         case (bus.cmd_code)
            `UHIM_RD_MASK: begin
               d.rsp_valid = 1'b1;
               d.rdata = q.mask & VALID;
            end
            `UHIM_RD_MCLR: begin
               // No storage behind this view
               d.rsp_valid = 1'b1;
               d.rdata = q.mask & VALID;
            end
            `UHIM_WR_MASK: begin
               d.mask = q.mask | wmask;
            end
            `UHIM_WR_MCLR: begin
               // Gate and event bits cleared alike
               d.mask = q.mask & ~wmask;
            end
            `UHIM_RD_FLB: begin
               d.rsp_valid = 1'b1;
               d.rdata = {q.interval_change_toggle, q.budget, 2'h0, q.fi};
            end
            `UHIM_WR_FLB: begin
               // Reserved bits 15:14 dropped
               d.fi = bus.cmd_wdata[`UHIM_FI_MSB:`UHIM_FI_LSB];
               d.budget =
                  bus.cmd_wdata[`UHIM_BUDGET_MSB:`UHIM_BUDGET_LSB];
               d.interval_change_toggle = bus.cmd_wdata[`UHIM_FIT_BIT];
            end
            default: begin
               // Unknown reads answer zero so the host never hangs
               if (!bus.cmd_code[`UHIM_CODE_WR_BIT]) begin
                  d.rsp_valid = 1'b1;
                  d.rdata = 32'h0000_0000;
               end
            end
         endcase
      end

      // Soft reset wins over a same-cycle write of the length
      if (soft_reset_i) begin
         d.fi = `UHIM_FI_RST;
      end

      if (xfer_valid_i) begin
         if (fits) begin
            d.pkt = q.pkt - xfer_bits_i;
         end else begin
            d.ovr = 1'b1;
         end
      end

      // Frame timer; a reload also refills the budget counter
      if (bit_tick_i) begin
         if (q.left == 14'h0000) begin
            d.left = q.fi;
            d.remaining_toggle_copy = q.interval_change_toggle;
            d.pkt = q.budget;
            d.sof = 1'b1;
         end else begin
            d.left = q.left - 14'h0001;
         end
      end

      d.irq = q.mask[`UHIM_GATE_BIT]
         & (|(event_flags_i & q.mask[6:0] & VALID[6:0]));
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q <= RST;
      end else begin
         q <= d;
      end
   end

   assign bus.rsp_valid = q.rsp_valid;
   assign bus.rsp_rdata = q.rdata;
   assign bus.frame_begin = q.sof;
   assign xfer_fits_o = fits;
   assign sched_overrun_o = q.ovr;
   assign irq_o = q.irq;
   assign frame_left_o = q.left;
   assign remaining_toggle_o = q.remaining_toggle_copy;
   assign packet_left_o = q.pkt;
   assign irq_mask_o = q.mask;

endmodule : uhim_dev

// ---- verilog/uhim_defs.svh ----
// Constants for the interrupt mask and frame interval register bank.
// Assumes inclusion by bare name from package and module files.
`ifndef UHIM_DEFS_SVH
`define UHIM_DEFS_SVH

// Command codes, read in the low half, write with bit 7 set
`define UHIM_RD_MASK 8'h04
`define UHIM_WR_MASK 8'h84
`define UHIM_RD_MCLR 8'h05
`define UHIM_WR_MCLR 8'h85
`define UHIM_RD_FLB 8'h0d
`define UHIM_WR_FLB 8'h8d
`define UHIM_CODE_WR_BIT 7

// Interrupt mask layout
`define UHIM_GATE_BIT 31
`define UHIM_EV_ROOT 6
`define UHIM_EV_WRAP 5
`define UHIM_EV_FAULT 4
`define UHIM_EV_RESUME 3
`define UHIM_EV_FRAME 2
`define UHIM_EV_OVERRUN 0
`define UHIM_MASK_VALID 32'h8000_007d
`define UHIM_MASK_RST 32'h0000_0000

// Frame length and packet budget layout
`define UHIM_FI_LSB 0
`define UHIM_FI_MSB 13
`define UHIM_BUDGET_LSB 16
`define UHIM_BUDGET_MSB 30
`define UHIM_FIT_BIT 31
`define UHIM_FI_RST 14'h2edf
`define UHIM_BUDGET_RST 15'h0000

`endif

// ---- verilog/uhim_pkg.sv ----
// Types shared by both ends of the register bank.
// Assumes uhim_defs.svh is on the include path.
`include "uhim_defs.svh"

package uhim_pkg;

   typedef enum logic [2:0] {
      UHIM_OP_READ = 3'h0,
      UHIM_OP_WRITE = 3'h1,
      UHIM_OP_SAVE = 3'h2,
      UHIM_OP_RESTORE = 3'h3,
      UHIM_OP_TUNE = 3'h4
   } uhim_op_e;

   typedef enum logic [1:0] {
      UHIM_HS_IDLE = 2'h0,
      UHIM_HS_SEND = 2'h1,
      UHIM_HS_WAIT = 2'h3,
      UHIM_HS_SOF = 2'h2
   } uhim_hst_e;

   typedef struct packed {
      logic [31:0] mask;
      logic [13:0] fi;
      logic [14:0] budget;
      logic interval_change_toggle;
      logic [13:0] left;
      logic remaining_toggle_copy;
      logic [14:0] pkt;
      logic rsp_valid;
      logic [31:0] rdata;
      logic sof;
      logic irq;
      logic ovr;
   } uhim_dev_s;

   typedef struct packed {
      uhim_hst_e st;
      uhim_op_e op;
      logic [7:0] code;
      logic [31:0] wdata;
      logic [31:0] saved;
      logic interval_change_toggle;
      logic [31:0] rdata;
      logic rvalid;
   } uhim_host_s;

endpackage : uhim_pkg

// ---- verilog/uhim_if.sv ----
// Command bus between the host processor end and the register bank.
// Assumes both ends share one clock; no tri-state lines.
`timescale 1ns/100ps

interface uhim_if;
   logic cmd_valid;
   logic [7:0] cmd_code;
   logic [31:0] cmd_wdata;
   logic rsp_valid;
   logic [31:0] rsp_rdata;
   logic frame_begin;

   modport dev_mp (
      input cmd_valid,
      input cmd_code,
      input cmd_wdata,
      output rsp_valid,
      output rsp_rdata,
      output frame_begin
   );

   modport host_mp (
      output cmd_valid,
      output cmd_code,
      output cmd_wdata,
      input rsp_valid,
      input rsp_rdata,
      input frame_begin
   );
endinterface : uhim_if

// ---- verilog/uhim_host.sv ----
// Host processor end: issues command codes, keeps the length toggle
// shadow, saves and restores the frame length, tunes at frame start.
// Assumes one outstanding command; the bank answers reads next cycle.
`timescale 1ns/100ps
`include "uhim_defs.svh"

module uhim_host
   import uhim_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   uhim_if.host_mp bus,
   input wire logic op_valid_i,
   input wire uhim_op_e op_i,
   input wire logic [7:0] code_i,
   input wire logic [31:0] wdata_i,
   output logic op_ready_o,
   output logic [31:0] rdata_o,
   output logic rdata_valid_o,
   output logic [31:0] saved_o
);

   localparam uhim_host_s RST = '{
      st: UHIM_HS_IDLE,
      op: UHIM_OP_READ,
      default: '0
   };

   uhim_host_s q;
   uhim_host_s d;

   always_comb begin
      d = q;
      d.rvalid = 1'b0;
      unique case (q.st)
         UHIM_HS_IDLE: begin
            if (op_valid_i) begin
               d.op = op_i;
               d.code = code_i;
               d.wdata = wdata_i;
               d.st = UHIM_HS_SEND;
               case (op_i)
                  UHIM_OP_SAVE: begin
                     // Kept before a soft reset
                     d.code = `UHIM_RD_FLB;
                  end
                  UHIM_OP_RESTORE: begin
                     d.code = `UHIM_WR_FLB;
                     d.wdata = {~q.interval_change_toggle, q.saved[30:0]};
                  end
                  UHIM_OP_TUNE: begin
                     // Budget comes from the caller
                     d.code = `UHIM_WR_FLB;
                     d.wdata = {~q.interval_change_toggle, wdata_i[30:0]};
                     d.st = UHIM_HS_SOF;
                  end
                  default: begin
                     d.st = UHIM_HS_SEND;
                  end
               endcase
            end
         end
         UHIM_HS_SOF: begin
            // Small steps only land right after a frame start
            if (bus.frame_begin) begin
               d.st = UHIM_HS_SEND;
            end
         end
         UHIM_HS_SEND: begin
            if (q.code[`UHIM_CODE_WR_BIT]) begin
               if (q.code == `UHIM_WR_FLB) begin
                  d.interval_change_toggle = q.wdata[`UHIM_FIT_BIT];
               end
               d.st = UHIM_HS_IDLE;
            end else begin
               d.st = UHIM_HS_WAIT;
            end
         end
         UHIM_HS_WAIT: begin
            if (bus.rsp_valid) begin
               d.rdata = bus.rsp_rdata;
               d.rvalid = 1'b1;
               d.st = UHIM_HS_IDLE;
               if (q.code == `UHIM_RD_FLB) begin
                  d.interval_change_toggle = bus.rsp_rdata[`UHIM_FIT_BIT];
               end
               if (q.op == UHIM_OP_SAVE) begin
                  d.saved = bus.rsp_rdata;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q <= RST;
      end else begin
         q <= d;
      end
   end

   assign bus.cmd_valid = (q.st == UHIM_HS_SEND);
   assign bus.cmd_code = q.code;
   assign bus.cmd_wdata = q.wdata;
   assign op_ready_o = (q.st == UHIM_HS_IDLE);
   assign rdata_o = q.rdata;
   assign rdata_valid_o = q.rvalid;
   assign saved_o = q.saved;

endmodule : uhim_host

// ---- bench/uhim_properties.sv ----
// Checker on the command bus joining host end and register bank.
// Assumes one clock; placed beside the interface in the bench.
`timescale 1ns/100ps
`include "uhim_defs.svh"

module uhim_properties (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic [31:0] cmd_wdata,
   input wire logic rsp_valid,
   input wire logic [31:0] rsp_rdata,
   input wire logic frame_begin
);
   // Mask shadow built from bus traffic only, never from the bank
   logic [31:0] mask_q;
   logic rd_q;
   logic [7:0] code_q;
   logic rd_mask;
   logic known;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mask_q <= `UHIM_MASK_RST;
         rd_q <= 1'b0;
         code_q <= 8'h00;
      end else begin
         rd_q <= cmd_valid && !cmd_code[7];
         if (cmd_valid) begin
            code_q <= cmd_code;
         end
         if (cmd_valid && cmd_code == `UHIM_WR_MASK) begin
            mask_q <= mask_q | (cmd_wdata & `UHIM_MASK_VALID);
         end
         if (cmd_valid && cmd_code == `UHIM_WR_MCLR) begin
            mask_q <= mask_q & ~cmd_wdata;
         end
      end
   end
   assign rd_mask = code_q == `UHIM_RD_MASK || code_q == `UHIM_RD_MCLR;
   assign known = rd_mask || code_q == `UHIM_RD_FLB;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   property p_read_answer;
      cmd_valid && !cmd_code[7] |=> rsp_valid;
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read command not answered");
   property p_no_stray;
      rsp_valid |-> rd_q;
   endproperty
   a_no_stray: assert property (p_no_stray)
      else $error("answer without read");
   property p_mask_view;
      rsp_valid && rd_q && rd_mask |-> rsp_rdata == mask_q;
   endproperty
   a_mask_view: assert property (p_mask_view)
      else $error("mask read differs");
   property p_mask_rsvd;
      rsp_valid && rd_q && rd_mask |-> (rsp_rdata & ~`UHIM_MASK_VALID) == 0;
   endproperty
   a_mask_rsvd: assert property (p_mask_rsvd)
      else $error("mask reserved bit set");
   property p_len_rsvd;
      rsp_valid && rd_q && code_q == `UHIM_RD_FLB |-> rsp_rdata[15:14] == 0;
   endproperty
   a_len_rsvd: assert property (p_len_rsvd)
      else $error("length reserved bit set");
   property p_unknown_zero;
      rsp_valid && rd_q && !known |-> rsp_rdata == 32'h0;
   endproperty
   a_unknown_zero: assert property (p_unknown_zero)
      else $error("unknown read not zero");
   property p_rdata_hold;
      !rsp_valid |-> $stable(rsp_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data moved");
   property p_frame_pulse;
      frame_begin |=> !frame_begin;
   endproperty
   a_frame_pulse: assert property (p_frame_pulse)
      else $error("frame start too long");

   c_mask_read: cover property (rsp_valid && rd_q && rd_mask);
   c_frame: cover property (frame_begin);
   c_len_write: cover property (cmd_valid && cmd_code == `UHIM_WR_FLB);
endmodule : uhim_properties

// ---- bench/usb_host_irq_mask_frame_interval_tb.sv ----
// Bench joining host end and register bank through the interface.
// Assumes reads come back on rdata_valid_o in issue order.
`timescale 1ns/100ps
`include "uhim_defs.svh"

module usb_host_irq_mask_frame_interval_tb;
   import uhim_pkg::*;
   logic clk_i = 0;
   logic nrst_i = 0;
   logic op_valid_i, op_ready_o, rdata_valid_o;
   uhim_op_e op_i;
   logic [7:0] code_i;
   logic [31:0] wdata_i, rdata_o, saved_o, irq_mask_o, m, r;
   logic soft_reset_i, bit_tick_i, xfer_valid_i, xfer_fits_o;
   logic sched_overrun_o, irq_o, remaining_toggle_o;
   logic [6:0] event_flags_i;
   logic [14:0] xfer_bits_i, packet_left_o;
   logic [13:0] frame_left_o;
   logic [31:0] exp_q[$];
   int fail_count = 0;
   int checks = 0;

   always #20 clk_i = ~clk_i;

   uhim_if uhim_if_i ();
   uhim_dev uhim_dev_i (.clk_i(clk_i), .nrst_i(nrst_i), .bus(uhim_if_i),
      .soft_reset_i(soft_reset_i), .bit_tick_i(bit_tick_i),
      .event_flags_i(event_flags_i), .xfer_valid_i(xfer_valid_i),
      .xfer_bits_i(xfer_bits_i), .xfer_fits_o(xfer_fits_o),
      .sched_overrun_o(sched_overrun_o), .irq_o(irq_o),
      .frame_left_o(frame_left_o), .remaining_toggle_o(remaining_toggle_o),
      .packet_left_o(packet_left_o), .irq_mask_o(irq_mask_o));
   uhim_host uhim_host_i (.clk_i(clk_i), .nrst_i(nrst_i), .bus(uhim_if_i),
      .op_valid_i(op_valid_i), .op_i(op_i), .code_i(code_i),
      .wdata_i(wdata_i), .op_ready_o(op_ready_o), .rdata_o(rdata_o),
      .rdata_valid_o(rdata_valid_o), .saved_o(saved_o));
   uhim_properties uhim_properties_i (.clk_i(clk_i), .nrst_i(nrst_i),
      .cmd_valid(uhim_if_i.cmd_valid), .cmd_code(uhim_if_i.cmd_code),
      .cmd_wdata(uhim_if_i.cmd_wdata), .rsp_valid(uhim_if_i.rsp_valid),
      .rsp_rdata(uhim_if_i.rsp_rdata), .frame_begin(uhim_if_i.frame_begin));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up();
      if (fail_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up

   task automatic op(input uhim_op_e o, input logic [7:0] c,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(negedge clk_i);
      while (op_ready_o !== 1'b1 && n < 50) begin
         @(negedge clk_i);
         n++;
      end
      op_valid_i = 1;
      op_i = o;
      code_i = c;
      wdata_i = d;
      @(negedge clk_i);
      op_valid_i = 0;
      repeat (3) @(negedge clk_i);
   endtask : op

   task automatic rd(input logic [7:0] c, input logic [31:0] e);
      exp_q.push_back(e);
      op(UHIM_OP_READ, c, 32'h0);
   endtask : rd

   task automatic tick(input int n);
      bit_tick_i = 1;
      repeat (n) @(negedge clk_i);
      bit_tick_i = 0;
   endtask : tick

   // Sampled off the edge, since rdata_valid_o is a one-cycle pulse
   always @(negedge clk_i) begin
      if (rdata_valid_o === 1'b1) begin
         check(rdata_o, exp_q.size() > 0 ? exp_q.pop_front() : 32'hx);
      end
   end

   initial begin
      #(40 * 20000);
      fail_count++;
      wrap_up();
   end

   initial begin
      op_valid_i = 0;
      op_i = UHIM_OP_READ;
      code_i = 8'h00;
      wdata_i = 32'h0;
      soft_reset_i = 0;
      bit_tick_i = 0;
      event_flags_i = 7'h00;
      xfer_valid_i = 0;
      xfer_bits_i = 15'h0000;
      m = 32'h0;
      void'($urandom(32'ha0831acc));
      repeat (10) @(negedge clk_i);
      nrst_i = 1;
      rd(`UHIM_RD_FLB, 32'h0000_2edf);
      op(UHIM_OP_WRITE, 8'h91, 32'hffff_ffff);
      rd(`UHIM_RD_MCLR, 32'h0);
      rd(8'h11, 32'h0);
      for (int i = 0; i < 6; i++) begin
         r = $urandom;
         op(UHIM_OP_WRITE, `UHIM_WR_MASK, r);
         m = m | (r & `UHIM_MASK_VALID);
         rd(`UHIM_RD_MASK, m);
         r = $urandom;
         op(UHIM_OP_WRITE, `UHIM_WR_MCLR, r);
         m = m & ~r;
         rd(`UHIM_RD_MCLR, m);
      end
      op(UHIM_OP_WRITE, `UHIM_WR_MASK, 32'hffff_ffff);
      for (int i = 0; i < 7; i++) begin
         event_flags_i = 7'h01 << i;
         repeat (2) @(negedge clk_i);
         check(irq_o, i != 1);
      end
      event_flags_i = 7'h7f;
      op(UHIM_OP_WRITE, `UHIM_WR_MCLR, 32'h8000_0000);
      check(irq_o, 1'b0);
      check(irq_mask_o, 32'h0000_007d);
      event_flags_i = 7'h00;
      op(UHIM_OP_WRITE, `UHIM_WR_FLB, 32'h8014_c003);
      rd(`UHIM_RD_FLB, 32'h8014_0003);
      tick(1);
      check(frame_left_o, 14'd3);
      check(remaining_toggle_o, 1'b1);
      check(packet_left_o, 15'd20);
      xfer_bits_i = 15'd21;
      xfer_valid_i = 1;
      #1 check(xfer_fits_o, 1'b0);
      @(negedge clk_i);
      xfer_valid_i = 0;
      check(sched_overrun_o, 1'b1);
      xfer_bits_i = 15'd20;
      xfer_valid_i = 1;
      @(negedge clk_i);
      xfer_valid_i = 0;
      check(packet_left_o, 15'd0);
      check(sched_overrun_o, 1'b0);
      tick(3);
      check(frame_left_o, 14'd0);
      tick(1);
      check(frame_left_o, 14'd3);
      check(packet_left_o, 15'd20);
      exp_q.push_back(32'h8014_0003);
      op(UHIM_OP_SAVE, 8'h00, 32'h0);
      check(saved_o, 32'h8014_0003);
      soft_reset_i = 1;
      @(negedge clk_i);
      soft_reset_i = 0;
      rd(`UHIM_RD_FLB, 32'h8014_2edf);
      op(UHIM_OP_RESTORE, 8'h00, 32'h0);
      rd(`UHIM_RD_FLB, 32'h0014_0003);
      // Tune parks until a frame start, so no ticks means no send
      op(UHIM_OP_TUNE, 8'h00, 32'h0028_0004);
      check(op_ready_o, 1'b0);
      bit_tick_i = 1;
      rd(`UHIM_RD_FLB, 32'h8028_0004);
      bit_tick_i = 0;
      repeat (5) @(negedge clk_i);
      wrap_up();
   end
endmodule : usb_host_irq_mask_frame_interval_tb
